// *** src/sw_port_fwd.sv ***
// port state gating, igmp trap, static trimming and tail tag handling
//
// Operation
// - port 3 is the processor; ports 1 and 2 take five states
// - disable state: no forwarding or receiving, no learning on the port
// - blocking: only override static frames reach the processor
// - discarding: port out of topology and learns no addresses
// - learning: learns addresses, passes only processor traffic
// - forwarding: normal forward and receive, addresses learned
// - processor sits on port 3 over mii; only port with tags
// - port 3 frames carry one tag byte before the four-byte fcs
// - tag bits 1:0 carry source or destination port
// - tag bits 3:2 carry priority; other tag bits unused
// - igmp frames are trapped to the processor port only
// - igmp: ip in ethernet or snap, version 4, protocol 2
// - static multicast entries send only to their listed ports
// - override flag lets matches bypass disabled tx or rx
`timescale 1ns/1ps
module sw_port_fwd #(
    parameter int FIFO_DEPTH = sw_port_pkg::FIFO_DEPTH,
    parameter int DROP_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // lookup results in
    input wire logic desc_valid_i,
    output logic desc_ready_o,
    input wire sw_port_pkg::desc_t desc_i,
    // verdicts out
    output logic fwd_valid_o,
    input wire logic fwd_ready_i,
    output sw_port_pkg::fwd_t fwd_o
);

    // ==================================================================
    // configuration registers
    logic [1:0] glb_r;
    logic [2:0] prt_r [2];
    logic [DROP_W-1:0] drops_r;
    logic [DROP_W-1:0] drops_nxt;
    logic wb_req;
    logic wb_wr;

    // per user port control bits, index 0 is port 1
    function automatic logic tx_en(input logic [2:0] c);
        tx_en = c[sw_port_pkg::PRT_TX_EN];
    endfunction : tx_en

    function automatic logic rx_en(input logic [2:0] c);
        rx_en = c[sw_port_pkg::PRT_RX_EN];
    endfunction : rx_en

    function automatic logic lrn_dis(input logic [2:0] c);
        lrn_dis = c[sw_port_pkg::PRT_LRN_DIS];
    endfunction : lrn_dis

    // state shown to software; disable, blocking, listening look alike
    function automatic sw_port_pkg::stp_state_t decode_state(
        input logic [2:0] c);
        if (lrn_dis(c) && !rx_en(c) && !tx_en(c))
            decode_state = sw_port_pkg::ST_DISCARD;
        else if (!lrn_dis(c) && !rx_en(c) && !tx_en(c))
            decode_state = sw_port_pkg::ST_LEARNING;
        else if (!lrn_dis(c) && rx_en(c))
            decode_state = sw_port_pkg::ST_FORWARDING;
        else
            decode_state = sw_port_pkg::ST_ODD;
    endfunction : decode_state

    // byte update of the reflected ethernet crc
    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ sw_port_pkg::CRC_POLY) : (r >> 1);
        crc_byte = r;
    endfunction : crc_byte

    // ==================================================================
    // wishbone slave: one wait state, ack for one cycle
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

    // ack pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_req;
    end

    // writes; unmapped offsets and lanes other than 0 are ignored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            glb_r <= sw_port_pkg::GLB_RESET;
            prt_r[0] <= sw_port_pkg::PRT_RESET;
            prt_r[1] <= sw_port_pkg::PRT_RESET;
        end
        else if (wb_wr)
        begin
            if (wb_adr_i == sw_port_pkg::REG_GLOBAL)
                glb_r <= wb_dat_i[1:0];
            else if (wb_adr_i == sw_port_pkg::REG_PORT1)
                prt_r[0] <= wb_dat_i[2:0];
            else if (wb_adr_i == sw_port_pkg::REG_PORT2)
                prt_r[1] <= wb_dat_i[2:0];
        end
    end

    // read data; unmapped offsets read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= '0;
        else if (wb_req && !wb_we_i)
        begin
            wb_dat_o <= '0;
            if (wb_adr_i == sw_port_pkg::REG_GLOBAL)
                wb_dat_o[1:0] <= glb_r;
            else if (wb_adr_i == sw_port_pkg::REG_PORT1)
                wb_dat_o[2:0] <= prt_r[0];
            else if (wb_adr_i == sw_port_pkg::REG_PORT2)
                wb_dat_o[2:0] <= prt_r[1];
            else if (wb_adr_i == sw_port_pkg::REG_STATUS)
            begin
                wb_dat_o[sw_port_pkg::STS_P1_STATE +: 3] <=
                    decode_state(prt_r[0]);
                wb_dat_o[sw_port_pkg::STS_P2_STATE +: 3] <=
                    decode_state(prt_r[1]);
                wb_dat_o[sw_port_pkg::STS_DROPS +: DROP_W] <= drops_r;
            end
        end
    end

    // ==================================================================
    // forwarding decision, purely combinational from the descriptor and the control registers
    logic tail_en;
    logic igmp_en;
    logic from_cpu;
    logic [0:0] sidx;
    logic [2:0] sctl;
    logic is_igmp;
    logic ovr;
    logic [2:0] dest;
    logic [2:0] src_bit;
    logic [7:0] tag_out;
    sw_port_pkg::fwd_t verdict;
    logic fifo_ready;
    logic push;

    assign tail_en = glb_r[sw_port_pkg::GLB_TAIL_EN];
    assign igmp_en = glb_r[sw_port_pkg::GLB_IGMP_EN];
    assign from_cpu = (desc_i.src_port == sw_port_pkg::PORT3);
    assign sidx = (desc_i.src_port == sw_port_pkg::PORT2) ? 1'b1 : 1'b0;
    assign sctl = prt_r[sidx];
    assign ovr = desc_i.static_hit && desc_i.static_ovr;
    // parser flags ip in both ethernet and snap framing
    assign is_igmp = igmp_en && desc_i.ip_frame
        && (desc_i.ip_ver == sw_port_pkg::IGMP_IP_VER)
        && (desc_i.ip_proto == sw_port_pkg::IGMP_IP_PROTO);

    // the verdict: lookup, then ingress gate, then egress gate
    always_comb
    begin
        src_bit = '0;
        src_bit[desc_i.src_port - 2'h1] = 1'b1;
        // address based destination
        if (from_cpu && tail_en &&
            (desc_i.tag[sw_port_pkg::TAG_PORT_LSB +: 2] != 2'h0))
        begin
            // tagged frame from the processor picks its ports
            dest = {1'b0, desc_i.tag[sw_port_pkg::TAG_PORT_LSB +: 2]};
        end
        else if (!from_cpu && is_igmp)
            dest = 3'h4;
        else if (desc_i.static_hit)
            dest = desc_i.static_ports;
        else if (desc_i.dyn_hit)
            dest = desc_i.dyn_ports;
        else
            dest = 3'h7;
        dest = dest & ~src_bit;
        // ingress gate on a user port
        if (!from_cpu && !rx_en(sctl) && !ovr)
        begin
            // learning state still passes frames to the processor
            if (lrn_dis(sctl))
                dest = 3'h0;
            else
                dest = dest & 3'h4;
        end
        else if (!from_cpu && !rx_en(sctl) && ovr)
            dest = dest & 3'h4;
        // egress gate on each user port
        for (int p = 0; p < 2; p++)
        begin
            if (dest[p] && !tx_en(prt_r[p]) && !ovr)
            begin
                // processor may reach ports that are not discarding
                if (!(from_cpu && !lrn_dis(prt_r[p])))
                    dest[p] = 1'b0;
            end
        end
        // tag toward the processor: source port and priority
        tag_out = '0;
        tag_out[sw_port_pkg::TAG_PORT_LSB +: 2] = desc_i.src_port;
        tag_out[sw_port_pkg::TAG_PRIO_LSB +: 2] = desc_i.prio;
        verdict.dest = dest;
        // learning off in disable, blocking, listening, discarding
        verdict.learn = from_cpu || !lrn_dis(sctl);
        verdict.trapped = !from_cpu && is_igmp && (dest != 3'h0);
        verdict.tag_add = tail_en && !from_cpu &&
            dest[sw_port_pkg::MASK_P3];
        verdict.tag_strip = tail_en && from_cpu;
        verdict.tag = verdict.tag_add ? tag_out : '0;
        verdict.prio = (from_cpu && tail_en) ?
            desc_i.tag[sw_port_pkg::TAG_PRIO_LSB +: 2] : desc_i.prio;
        // running crc stops before the tag; fold it in or leave it out
        if (verdict.tag_add)
            verdict.fcs = ~crc_byte(desc_i.crc_pre, tag_out);
        else
            verdict.fcs = ~desc_i.crc_pre;
    end

    // ==================================================================
    // verdict queue; a stalled sink fills it and stalls the source
    sw_port_pkg::fwd_t q_data;
    logic q_valid;
    logic q_pop;

    assign push = desc_valid_i && fifo_ready;

    sw_fwd_fifo #(
        .WIDTH($bits(sw_port_pkg::fwd_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(desc_valid_i),
        .in_ready_o(fifo_ready),
        .in_data_i(verdict),
        .out_valid_o(q_valid),
        .out_ready_i(q_pop),
        .out_data_o(q_data)
    );

    // source ready mirrors the queue's registered not-full flag
    assign desc_ready_o = fifo_ready;

    // output register so every verdict port comes from a flop
    assign q_pop = q_valid && (!fwd_valid_o || fwd_ready_i);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fwd_valid_o <= 1'b0;
            fwd_o <= '0;
        end
        else if (!fwd_valid_o || fwd_ready_i)
        begin
            fwd_valid_o <= q_valid;
            if (q_valid)
                fwd_o <= q_data;
        end
    end

    // ==================================================================
    // count frames that end with no destination, saturating
    always_comb
    begin
        drops_nxt = drops_r;
        if (push && (verdict.dest == 3'h0) && (drops_r != '1))
            drops_nxt = drops_r + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            drops_r <= '0;
        else
            drops_r <= drops_nxt;
    end

endmodule : sw_port_fwd

// *** src/sw_port_pkg.sv ***
// package: offsets, fields, codes and carriers for the port forwarding block
package sw_port_pkg;

    // ==================================================================
    // register map (byte addresses)
    localparam logic [3:0] REG_GLOBAL = 4'h0;
    localparam logic [3:0] REG_PORT1 = 4'h4;
    localparam logic [3:0] REG_PORT2 = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;

    // ==================================================================
    // field positions
    localparam int GLB_TAIL_EN = 0;
    localparam int GLB_IGMP_EN = 1;
    localparam int PRT_TX_EN = 0;
    localparam int PRT_RX_EN = 1;
    localparam int PRT_LRN_DIS = 2;
    localparam int STS_P1_STATE = 0;
    localparam int STS_P2_STATE = 4;
    localparam int STS_DROPS = 16;

    // ==================================================================
    // reset values: user ports start in discarding, tagging and snoop on
    localparam logic [1:0] GLB_RESET = 2'h3;
    localparam logic [2:0] PRT_RESET = 3'h4;

    // ==================================================================
    // ports: destination mask bit per port, tag codes in bits 1:0
    localparam int NPORTS = 3;
    localparam int MASK_P1 = 0;
    localparam int MASK_P2 = 1;
    localparam int MASK_P3 = 2;
    localparam logic [1:0] PORT1 = 2'h1;
    localparam logic [1:0] PORT2 = 2'h2;
    localparam logic [1:0] PORT3 = 2'h3;
    localparam int TAG_PORT_LSB = 0;
    localparam int TAG_PRIO_LSB = 2;

    // ==================================================================
    // trap criteria and check sequence
    localparam logic [3:0] IGMP_IP_VER = 4'h4;
    localparam logic [7:0] IGMP_IP_PROTO = 8'h02;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam int FIFO_DEPTH = 4;

    // ==================================================================
    // state reported per user port
    typedef enum logic [2:0] {
        ST_DISCARD = 3'h0,
        ST_LEARNING = 3'h1,
        ST_FORWARDING = 3'h2,
        ST_ODD = 3'h3
    } stp_state_t;

    // per frame lookup result coming from parser and address tables
    typedef struct packed {
        logic [1:0] src_port;
        logic [7:0] tag;
        logic [1:0] prio;
        logic ip_frame;
        logic [3:0] ip_ver;
        logic [7:0] ip_proto;
        logic static_hit;
        logic static_ovr;
        logic [2:0] static_ports;
        logic dyn_hit;
        logic [2:0] dyn_ports;
        logic [31:0] crc_pre;
    } desc_t;

    // forwarding verdict
    typedef struct packed {
        logic [2:0] dest;
        logic learn;
        logic trapped;
        logic tag_add;
        logic tag_strip;
        logic [7:0] tag;
        logic [1:0] prio;
        logic [31:0] fcs;
    } fwd_t;

endpackage : sw_port_pkg

// *** src/sw_fwd_fifo.sv ***
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module sw_fwd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic push;
    logic pop;

    // ready is a flop so back-pressure does not ripple combinationally
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_r[rp_r];

    // pointer wrap
    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : nxt

    // storage
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    // pointers, level and flags
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end
        else
        begin
            if (push)
                wp_r <= nxt(wp_r);
            if (pop)
                rp_r <= nxt(rp_r);
            if (push && !pop)
            begin
                cnt_r <= cnt_r + 1'b1;
                in_ready_o <= (cnt_r != CW'(DEPTH - 1));
                out_valid_o <= 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_r <= cnt_r - 1'b1;
                in_ready_o <= 1'b1;
                out_valid_o <= (cnt_r != CW'(1));
            end
        end
    end

endmodule : sw_fwd_fifo

// *** tb/sw_port_fwd_chk.sv ***
// checker: bus handshake and verdict stream rules of the port block
`timescale 1ns/1ps
module sw_port_fwd_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // descriptor and verdict stream
    input wire logic desc_valid_i,
    input wire logic desc_ready_o,
    input wire logic fwd_valid_o,
    input wire logic fwd_ready_i,
    input wire sw_port_pkg::fwd_t fwd_o
);
    // ==================================================================
    // bus handshake: one registered ack per request
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o)
        else $error("request not acked on the next cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");

    // ==================================================================
    // stream: verdicts hold under back-pressure, short path when idle
    a_fwd_hold: assert property (fwd_valid_o && !fwd_ready_i
        |=> fwd_valid_o && $stable(fwd_o))
        else $error("verdict changed before it was taken");
    a_fwd_latency: assert property (desc_valid_i && desc_ready_o
        && !fwd_valid_o |-> ##[1:3] fwd_valid_o)
        else $error("verdict late on an idle path");

    // ==================================================================
    // verdict contents
    a_trap_cpu_only: assert property (fwd_valid_o && fwd_o.trapped
        |-> fwd_o.dest[1:0] == 2'h0)
        else $error("trapped frame sent to a user port");
    a_tag_fields: assert property (fwd_valid_o && fwd_o.tag_add
        |-> fwd_o.tag[7:4] == 4'h0 && fwd_o.tag[1:0] != 2'h0
        && fwd_o.tag[1:0] != 2'h3)
        else $error("inserted tag has bad port or unused bits");
    a_tag_prio: assert property (fwd_valid_o && fwd_o.tag_add
        |-> fwd_o.tag[3:2] == fwd_o.prio)
        else $error("inserted tag priority differs");
    a_tag_exclusive: assert property (fwd_valid_o
        |-> !(fwd_o.tag_add && fwd_o.tag_strip))
        else $error("tag both added and stripped");
    a_tag_to_cpu: assert property (fwd_valid_o && fwd_o.tag_add
        |-> fwd_o.dest[2])
        else $error("tag added on a frame not for the processor");
endmodule : sw_port_fwd_chk

bind sw_port_fwd sw_port_fwd_chk chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .desc_valid_i(desc_valid_i), .desc_ready_o(desc_ready_o),
    .fwd_valid_o(fwd_valid_o), .fwd_ready_i(fwd_ready_i), .fwd_o(fwd_o));

// *** tb/sw_verdict_sink.sv ***
// verdict sink standing in for the processor side of the stream
`timescale 1ns/1ps
module sw_verdict_sink (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control from bench
    input wire logic stall_i,
    // verdict stream
    input wire logic fwd_valid_i,
    input wire sw_port_pkg::fwd_t fwd_i,
    output logic fwd_ready_o,
    // what was taken, one cycle late
    output logic got_o,
    output sw_port_pkg::fwd_t got_data_o
);
    integer seed = 32'hf10d;

    // ==================================================================
    // random back-pressure, so the hold rule is really exercised
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fwd_ready_o <= 1'h0;
        else
            fwd_ready_o <= !stall_i && ($random(seed) % 4 != 0);
    end

    // every verdict is taken whole, as the dma side would
    always_ff @(posedge clk_i)
    begin
        got_o <= !rst_i && fwd_valid_i && fwd_ready_o;
        got_data_o <= fwd_i;
    end
endmodule : sw_verdict_sink

// *** tb/sw_port_fwd_bench.sv ***
// self-checking bench for the port forwarding block
`timescale 1ns/1ps
module sw_port_fwd_bench;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic desc_valid_i = 1'h0, desc_ready_o, fwd_valid_o, fwd_ready_i;
    logic stall = 1'h0, got;
    sw_port_pkg::desc_t desc_i = '0;
    sw_port_pkg::fwd_t fwd_o, got_d;
    logic [4:0] exp_q[$];
    logic [4:0] exp_v;
    integer seed = 32'hf10d;
    int errors = 0, num_checks = 0, cycles = 0;

    // ==================================================================
    // design, stand-in processor side and clock
    sw_port_fwd uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .desc_valid_i(desc_valid_i),
        .desc_ready_o(desc_ready_o), .desc_i(desc_i),
        .fwd_valid_o(fwd_valid_o), .fwd_ready_i(fwd_ready_i), .fwd_o(fwd_o));
    sw_verdict_sink sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
        .fwd_valid_i(fwd_valid_o), .fwd_i(fwd_o), .fwd_ready_o(fwd_ready_i),
        .got_o(got), .got_data_o(got_d));
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    // ==================================================================
    // helpers
    task check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // classic cycle: hold everything until ack is sampled
    task wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
        input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'h1 && ++n < 50);
        if (n >= 50)
        begin
            errors++;
            summarize();
        end
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb

    task rdchk(input logic [3:0] adr, input logic [31:0] exp);
        wb(1'h0, adr, 32'h0, 4'hf);
        check("read data", wb_dat_o, exp);
    endtask : rdchk

    // one descriptor, expectation noted when it is taken
    task send(input sw_port_pkg::desc_t d, input logic [4:0] e);
        int n;
        n = 0;
        @(posedge clk_i);
        desc_valid_i <= 1'h1;
        desc_i <= d;
        do
            @(posedge clk_i);
        while (desc_ready_o !== 1'h1 && ++n < 50);
        if (n >= 50)
        begin
            errors++;
            summarize();
        end
        exp_q.push_back(e);
        desc_valid_i <= 1'h0;
    endtask : send

    // so: static hit and override; ip frame when version is nonzero
    function automatic sw_port_pkg::desc_t mk(input logic [1:0] src,
        input logic [7:0] tag, input logic [3:0] ver, input logic [7:0] pro,
        input logic [2:0] sp, input logic [1:0] so, input logic [2:0] dp);
        sw_port_pkg::desc_t d;
        d = '0;
        d.src_port = src;
        d.tag = tag;
        d.prio = 2'($random(seed));
        d.ip_frame = ver != 4'h0;
        d.ip_ver = ver;
        d.ip_proto = pro;
        {d.static_hit, d.static_ovr} = so;
        d.static_ports = sp;
        d.dyn_hit = dp != 3'h0;
        d.dyn_ports = dp;
        d.crc_pre = $random(seed);
        return d;
    endfunction : mk

    task drain;
        int n;
        for (n = 0; n < 200 && exp_q.size() != 0; n++)
            @(posedge clk_i);
        if (n == 200)
        begin
            errors++;
            summarize();
        end
    endtask : drain

    task summarize;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // ==================================================================
    // watcher: oldest note against each taken verdict
    always @(posedge clk_i)
    begin
        if (got === 1'h1)
        begin
            exp_v = exp_q.size() != 0 ? exp_q.pop_front() : 5'h1f;
            check("dest learn trap", {27'h0, got_d.dest, got_d.learn,
                got_d.trapped}, {27'h0, exp_v});
        end
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            summarize();
        end
    end

    // ==================================================================
    // main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        rdchk(sw_port_pkg::REG_STATUS, 32'h0);
        rdchk(sw_port_pkg::REG_GLOBAL, 32'h3);
        rdchk(sw_port_pkg::REG_PORT1, 32'h4);
        wb(1'h1, 4'h2, 32'hff, 4'hf);
        rdchk(4'h2, 32'h0);
        wb(1'h1, sw_port_pkg::REG_PORT1, 32'h3, 4'h1);
        wb(1'h1, sw_port_pkg::REG_PORT2, 32'h3, 4'h1);
        wb(1'h1, sw_port_pkg::REG_PORT1, 32'h0, 4'h0);
        wb(1'h1, sw_port_pkg::REG_STATUS, 32'hffffffff, 4'hf);
        rdchk(sw_port_pkg::REG_PORT1, 32'h3);
        rdchk(sw_port_pkg::REG_STATUS, 32'h22);
        send(mk(2'h1, 8'h0, 4'h0, 8'h0, 3'h0, 2'h0, 3'h2), 5'h0a);
        send(mk(2'h1, 8'h0, 4'h4, 8'h2, 3'h0, 2'h0, 3'h2), 5'h13);
        send(mk(2'h1, 8'h0, 4'h4, 8'h3, 3'h0, 2'h0, 3'h0), 5'h1a);
        send(mk(2'h1, 8'h0, 4'h6, 8'h2, 3'h0, 2'h0, 3'h0), 5'h1a);
        send(mk(2'h3, 8'h0, 4'h0, 8'h0, 3'h3, 2'h2, 3'h4), 5'h0e);
        send(mk(2'h3, 8'h2, 4'h0, 8'h0, 3'h0, 2'h0, 3'h0), 5'h0a);
        send(mk(2'h3, 8'hd, 4'h0, 8'h0, 3'h0, 2'h0, 3'h0), 5'h06);
        send(mk(2'h3, 8'hf2, 4'h0, 8'h0, 3'h0, 2'h0, 3'h0), 5'h0a);
        drain();
        // stall the sink so the buffer fills and refuses, then drains
        stall <= 1'h1;
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 5; i++)
            send(mk(2'h2, 8'h0, 4'h0, 8'h0, 3'h0, 2'h0, {i[0], 2'h1}),
                {i[0], 2'h1, 2'h2});
        repeat (2) @(posedge clk_i);
        check("desc ready when full", {31'h0, desc_ready_o}, 32'h0);
        stall <= 1'h0;
        drain();
        wb(1'h1, sw_port_pkg::REG_PORT1, 32'h4, 4'h1);
        send(mk(2'h1, 8'h0, 4'h0, 8'h0, 3'h0, 2'h0, 3'h2), 5'h00);
        // processor loads override entries for frames it must see
        send(mk(2'h1, 8'h0, 4'h0, 8'h0, 3'h4, 2'h3, 3'h0), 5'h10);
        send(mk(2'h1, 8'h0, 4'h0, 8'h0, 3'h4, 2'h2, 3'h0), 5'h00);
        send(mk(2'h2, 8'h0, 4'h0, 8'h0, 3'h0, 2'h0, 3'h1), 5'h02);
        // processor sends only toward port 2 while port 1 discards
        send(mk(2'h3, 8'h2, 4'h0, 8'h0, 3'h0, 2'h0, 3'h0), 5'h0a);
        drain();
        rdchk(sw_port_pkg::REG_STATUS, 32'h0003_0020);
        wb(1'h1, sw_port_pkg::REG_PORT1, 32'h0, 4'h1);
        send(mk(2'h1, 8'h0, 4'h0, 8'h0, 3'h0, 2'h0, 3'h6), 5'h12);
        send(mk(2'h3, 8'h1, 4'h0, 8'h0, 3'h0, 2'h0, 3'h0), 5'h06);
        send(mk(2'h2, 8'h0, 4'h0, 8'h0, 3'h0, 2'h0, 3'h1), 5'h02);
        drain();
        rdchk(sw_port_pkg::REG_STATUS, 32'h0004_0021);
        summarize();
    end
endmodule : sw_port_fwd_bench
